// [verilog/host_port_pin_function_select.sv]
// module: pin-function selection and data path of the 22-pin host port
`timescale 1ns/100ps
module host_port_pin_function_select
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // core register port
    input wire host_port_pkg::reg_req_t req,
    output logic [23:0] rdata,
    output logic irq,
    // host side strobes (decoded from the selected bus)
    input wire logic host_tx_wr,
    input wire logic [23:0] host_tx_data,
    input wire logic host_rx_rd,
    input wire logic host_cmd_wr,
    input wire logic [7:0] host_cmd_vec,
    // pads
    input wire logic [21:0] pad_in,
    output host_port_pkg::pad_drive_t pad,
    // decoded host bus fields
    output logic [10:0] generic_address,
    output logic [15:0] muxed_addr_data_in,
    output logic [3:0] command_byte_enable_lines,
    output logic target_ready_in,
    output logic initiator_ready_in,
    output logic [7:0] command_vector,
    output logic host_command_bit,
    // host view of receive path
    output logic [23:0] host_rx_data,
    output logic receive_full_flag,
    output logic transmit_empty_flag
);
    // software registers
    logic [23:0] port_control_register; // mode and polarity
    logic [21:0] pin_direction_register; // one = output in gpio mode
    logic [21:0] gpio_out_reg; // gpio drive values
    logic [2:0] mask_reg; // interrupt mask
    logic [2:0] status_reg; // sticky events
    logic [23:0] core_side_receive_register; // filled from transmit bytes
    logic [23:0] transmit_bytes_reg; // transmit_byte_high/middle/low
    logic [23:0] receive_bytes_reg; // receive_byte_high/middle/low
    logic core_rx_full_reg; // core register holds unread data
    logic [21:0] pad_in_reg; // registered pad samples
    // host-side core outputs driven onto the muxed bus
    logic [15:0] pci_ad_out_reg;
    logic [3:0] pci_cbe_out_reg;
    logic pci_ad_oe_reg;
    logic [7:0] generic_data_out_reg;
    logic generic_read_reg;
    host_port_pkg::pin_mode_t mode;

    // decode the mode field; an unused code leaves every pin released
    function automatic host_port_pkg::pin_mode_t decode_mode(input logic [23:0] ctrl);
        unique case (ctrl[host_port_pkg::MODE_LSB +: 2])
            host_port_pkg::MODE_GPIO: decode_mode = host_port_pkg::PIN_GPIO;
            host_port_pkg::MODE_PCI: decode_mode = host_port_pkg::PIN_PCI;
            host_port_pkg::MODE_GENERIC: decode_mode = host_port_pkg::PIN_GENERIC;
            default: decode_mode = host_port_pkg::PIN_OFF;
        endcase
    endfunction

    // write decode helper
    function automatic logic wr_hit(input host_port_pkg::reg_req_t r, input logic [3:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    assign mode = decode_mode(port_control_register);

    // control register: the only source of pin function
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            port_control_register <= host_port_pkg::CTRL_RESET;
        else if (wr_hit(req, host_port_pkg::OFS_CTRL))
            port_control_register <= req.wdata;
    end

    // direction and gpio data registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_direction_register <= host_port_pkg::DIR_RESET;
            gpio_out_reg <= host_port_pkg::DIR_RESET;
        end
        else
        begin
            if (wr_hit(req, host_port_pkg::OFS_DIR))
                pin_direction_register <= req.wdata[21:0];
            if (wr_hit(req, host_port_pkg::OFS_GPIO_OUT))
                gpio_out_reg <= req.wdata[21:0];
        end
    end

    // host-bus drive values that the core loads for pci and generic cycles
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pci_ad_out_reg <= 16'h0000;
            pci_cbe_out_reg <= 4'h0;
            pci_ad_oe_reg <= 1'b0;
            generic_data_out_reg <= 8'h00;
            generic_read_reg <= 1'b0;
        end
        else
        begin
            // a host read of the receive bytes turns the bus towards the host
            generic_read_reg <= host_rx_rd;
            pci_ad_oe_reg <= host_rx_rd;
            pci_ad_out_reg <= receive_bytes_reg[15:0];
            pci_cbe_out_reg <= 4'h0;
            generic_data_out_reg <= receive_bytes_reg[7:0];
        end
    end

    // pad drive: two flops per pin (out and oe), muxed by mode; reset releases every pin
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pad.out <= 22'h00_0000;
            pad.oe <= 22'h00_0000;
        end
        else
        begin
            unique case (mode)
                host_port_pkg::PIN_PCI:
                begin
                    pad.out <= {2'b00, pci_cbe_out_reg, pci_ad_out_reg};
                    pad.oe <= {2'b00, {4{1'b0}}, {16{pci_ad_oe_reg}}};
                    // target-ready pin 20 driven low-active by the target when answering; initiator-ready pin 21 is never driven
                    pad.out[20] <= !pci_ad_oe_reg;
                    pad.oe[20] <= pci_ad_oe_reg;
                    pad.oe[21] <= 1'b0;
                end
                host_port_pkg::PIN_GENERIC:
                begin
                    pad.out <= {1'b0, 1'b0, 4'h0, generic_data_out_reg, 8'h00};
                    pad.oe <= {2'b11, 4'h0, {8{generic_read_reg}}, 8'h00};
                    pad.out[20] <= generic_read_reg;
                    pad.out[21] <= generic_read_reg
                        ^ port_control_register[host_port_pkg::DIR_POL_BIT];
                end
                host_port_pkg::PIN_GPIO:
                begin
                    pad.out <= gpio_out_reg;
                    pad.oe <= pin_direction_register;
                end
                default:
                begin
                    pad.out <= 22'h00_0000;
                    pad.oe <= 22'h00_0000;
                end
            endcase
        end
    end

    // pad sampling and decoded host-bus fields
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pad_in_reg <= 22'h00_0000;
            generic_address <= 11'h000;
            muxed_addr_data_in <= 16'h0000;
            command_byte_enable_lines <= 4'h0;
            target_ready_in <= 1'b0;
            initiator_ready_in <= 1'b0;
        end
        else
        begin
            pad_in_reg <= pad_in;
            generic_address <= (mode == host_port_pkg::PIN_GENERIC)
                ? {pad_in[7:0], pad_in[18:16]} : 11'h000;
            muxed_addr_data_in <= (mode == host_port_pkg::PIN_PCI)
                ? pad_in[15:0] : 16'h0000;
            command_byte_enable_lines <= (mode == host_port_pkg::PIN_PCI)
                ? pad_in[19:16] : 4'h0;
            target_ready_in <= (mode == host_port_pkg::PIN_PCI) && pad_in[20];
            initiator_ready_in <= (mode == host_port_pkg::PIN_PCI) && pad_in[21];
        end
    end

    // transmit bytes from the host, moved to the core register when it is free
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            transmit_bytes_reg <= 24'h00_0000;
            transmit_empty_flag <= 1'b1;
            core_side_receive_register <= 24'h00_0000;
            core_rx_full_reg <= 1'b0;
        end
        else
        begin
            // writes while not empty are ignored; the host must wait for the flag
            if (host_tx_wr && transmit_empty_flag)
            begin
                transmit_bytes_reg <= host_tx_data;
                transmit_empty_flag <= 1'b0;
            end
            else if (!transmit_empty_flag && !core_rx_full_reg)
            begin
                core_side_receive_register <= transmit_bytes_reg;
                core_rx_full_reg <= 1'b1;
                transmit_empty_flag <= 1'b1;
            end
            // a core read frees the register even while the next word waits behind it
            if (req.rd && req.addr == host_port_pkg::OFS_CORE_RX && core_rx_full_reg)
                core_rx_full_reg <= 1'b0;
        end
    end

    // receive bytes loaded by the core, read by the host
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            receive_bytes_reg <= 24'h00_0000;
            receive_full_flag <= 1'b0;
            host_rx_data <= 24'h00_0000;
        end
        else
        begin
            if (wr_hit(req, host_port_pkg::OFS_CORE_TX) && !receive_full_flag)
            begin
                receive_bytes_reg <= req.wdata;
                receive_full_flag <= 1'b1;
            end
            else if (host_rx_rd && receive_full_flag)
                receive_full_flag <= 1'b0;
            host_rx_data <= receive_full_flag ? receive_bytes_reg : 24'h00_0000;
        end
    end

    // command vector: latched with the command bit; core clears the bit
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            command_vector <= 8'h00;
            host_command_bit <= 1'b0;
        end
        else
        begin
            // vector is only taken while the bit is clear, so the core sees it stable
            if (host_cmd_wr && !host_command_bit)
            begin
                command_vector <= host_cmd_vec;
                host_command_bit <= 1'b1;
            end
            else if (wr_hit(req, host_port_pkg::OFS_CMD) && req.wdata[0])
                host_command_bit <= 1'b0;
        end
    end

    // sticky status: an event in the clearing cycle wins over the clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_reg <= host_port_pkg::ST_RESET;
            mask_reg <= host_port_pkg::ST_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_hit(req, host_port_pkg::OFS_MASK))
                mask_reg <= req.wdata[2:0];
            status_reg <= (status_reg & ~(wr_hit(req, host_port_pkg::OFS_STATUS)
                ? req.wdata[2:0] : 3'h0))
                | {host_cmd_wr && !host_command_bit,
                   !transmit_empty_flag && !core_rx_full_reg,
                   host_rx_rd && receive_full_flag};
            irq <= |(status_reg & mask_reg);
        end
    end

    // read data, valid the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 24'h00_0000;
        else if (req.rd)
        begin
            unique case (req.addr)
                host_port_pkg::OFS_CTRL: rdata <= port_control_register;
                host_port_pkg::OFS_DIR: rdata <= {2'b00, pin_direction_register};
                host_port_pkg::OFS_GPIO_OUT: rdata <= {2'b00, gpio_out_reg};
                host_port_pkg::OFS_GPIO_IN: rdata <= {2'b00, pad_in_reg};
                host_port_pkg::OFS_TX: rdata <= transmit_bytes_reg;
                host_port_pkg::OFS_RX: rdata <= receive_bytes_reg;
                host_port_pkg::OFS_CMD: rdata <= {15'h0000, host_command_bit, command_vector};
                host_port_pkg::OFS_CORE_RX: rdata <= core_side_receive_register;
                host_port_pkg::OFS_STATUS: rdata <= {21'h00_0000, status_reg};
                host_port_pkg::OFS_MASK: rdata <= {21'h00_0000, mask_reg};
                default: rdata <= 24'h00_0000;
            endcase
        end
        else
            rdata <= 24'h00_0000;
    end

    // reset releases every pin, so nothing is driven in the cycle after it
    pins_released_a: assert property (@(posedge clk) !rst_b |=> pad.oe == 22'h00_0000)
        else $error("pins driven after reset");
    gpio_dir_a: assert property (@(posedge clk) disable iff (!rst_b)
        mode == host_port_pkg::PIN_GPIO && $stable(mode)
        |=> pad.oe == $past(pin_direction_register))
        else $error("gpio enable does not follow direction");
    sequence tx_pending_s; // a word waits while the core register is free
        !transmit_empty_flag && !core_rx_full_reg;
    endsequence
    tx_move_a: assert property (@(posedge clk) disable iff (!rst_b)
        tx_pending_s
        |=> core_rx_full_reg
        && core_side_receive_register == $past(transmit_bytes_reg))
        else $error("transmit bytes not moved");
    pci_cbe_in_a: assert property (@(posedge clk) disable iff (!rst_b)
        mode == host_port_pkg::PIN_PCI |=> command_byte_enable_lines == $past(pad_in[19:16]))
        else $error("command lines wrong");
    pci_ad_in_a: assert property (@(posedge clk) disable iff (!rst_b)
        mode == host_port_pkg::PIN_PCI |=> muxed_addr_data_in == $past(pad_in[15:0]))
        else $error("address/data wrong");
    gen_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
        mode == host_port_pkg::PIN_GENERIC
        |=> generic_address == {$past(pad_in[7:0]), $past(pad_in[18:16])})
        else $error("generic address wrong");
    gen_data_a: assert property (@(posedge clk) disable iff (!rst_b)
        mode == host_port_pkg::PIN_GENERIC && $stable(mode)
        |=> pad.oe[15:8] == {8{$past(generic_read_reg)}})
        else $error("generic data enable wrong");
    gen_enable_a: assert property (@(posedge clk) disable iff (!rst_b)
        mode == host_port_pkg::PIN_GENERIC && $stable(mode)
        |=> pad.oe[21:20] == 2'b11 && pad.out[20] == $past(generic_read_reg))
        else $error("data bus enable wrong");
    pci_ready_a: assert property (@(posedge clk) disable iff (!rst_b)
        mode == host_port_pkg::PIN_PCI |=> initiator_ready_in == $past(pad_in[21]) && !pad.oe[21])
        else $error("ready pins wrong");
    mode_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
        req.wr && req.addr == host_port_pkg::OFS_CTRL
        |=> port_control_register == $past(req.wdata))
        else $error("control not written");
endmodule // host_port_pin_function_select

// [verilog/host_port_pkg.sv]
// package: register map, field layout and types of the host port pin-function block
package host_port_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_DIR = 4'h1;
    localparam logic [3:0] OFS_GPIO_OUT = 4'h2;
    localparam logic [3:0] OFS_GPIO_IN = 4'h3;
    localparam logic [3:0] OFS_TX = 4'h4;
    localparam logic [3:0] OFS_RX = 4'h5;
    localparam logic [3:0] OFS_CMD = 4'h6;
    localparam logic [3:0] OFS_CORE_RX = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_MASK = 4'h9;
    localparam logic [3:0] OFS_CORE_TX = 4'hA;
    // control register fields
    localparam int CTRL_W = 24;
    localparam int MODE_LSB = 0;
    localparam int DIR_POL_BIT = 2;
    localparam logic [23:0] CTRL_RESET = 24'h00_0000;
    // mode codes in the control register
    localparam logic [1:0] MODE_GPIO = 2'h0;
    localparam logic [1:0] MODE_PCI = 2'h1;
    localparam logic [1:0] MODE_GENERIC = 2'h2;
    // pin count of the port
    localparam int PINS = 22;
    localparam logic [21:0] DIR_RESET = 22'h00_0000;
    // status bits
    localparam int ST_RX_FULL = 0;
    localparam int ST_TX_EMPTY = 1;
    localparam int ST_CMD = 2;
    localparam logic [2:0] ST_RESET = 3'h0;

    typedef enum logic [1:0] {PIN_GPIO, PIN_PCI, PIN_GENERIC, PIN_OFF} pin_mode_t;

    // one two-way pin group towards the pads
    typedef struct packed {
        logic [21:0] out;
        logic [21:0] oe;
    } pad_drive_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [23:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// [testbench/host_model.sv]
// host-side partner: drives host strobes, pad levels, and waits on the device flags
`timescale 1ns/100ps
module host_model
(
    // clock
    input wire logic clk,
    // device flags and data seen by the host
    input wire logic transmit_empty_flag,
    input wire logic receive_full_flag,
    input wire logic host_command_bit,
    input wire logic [23:0] host_rx_data,
    input wire host_port_pkg::pad_drive_t pad,
    // host strobes
    output logic host_tx_wr,
    output logic [23:0] host_tx_data,
    output logic host_rx_rd,
    output logic host_cmd_wr,
    output logic [7:0] host_cmd_vec,
    // resolved pad levels
    output logic [21:0] pad_in
);
    int gap = 0; // idle cycles before each action, to play a slow host
    logic [21:0] host_level = 22'h00_0000; // what the host drives on undriven pins
    // a pin driven by the device shows its value, otherwise the host's level
    assign pad_in = (pad.oe & pad.out) | (~pad.oe & host_level);
    // all strobes idle from time zero
    initial
    begin
        host_tx_wr = 1'b0;
        host_tx_data = 24'h00_0000;
        host_rx_rd = 1'b0;
        host_cmd_wr = 1'b0;
        host_cmd_vec = 8'h00;
    end
    // flag sampled at the edge, so no race with the device's own updates
    function automatic logic ready_of(input int k);
        return k == 0 ? transmit_empty_flag : (k == 1 ? receive_full_flag : !host_command_bit);
    endfunction
    // bounded wait: a stuck flag ends the wait and later checks catch it
    task automatic ready_wait(input int k);
        int n;
        n = 0;
        repeat (gap) @(posedge clk);
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ready_of(k) !== 1'b1 && n < 64);
    endtask
    // write transmit bytes only once they are empty
    task automatic send_tx(input logic [23:0] d);
        ready_wait(0);
        host_tx_wr <= 1'b1;
        host_tx_data <= d;
        @(posedge clk);
        host_tx_wr <= 1'b0;
        host_tx_data <= ~d; // released data no longer shows the old word
    endtask
    // read receive bytes only once the full flag says they are valid
    task automatic read_rx(output logic [23:0] d);
        ready_wait(1);
        d = host_rx_data;
        host_rx_rd <= 1'b1;
        @(posedge clk);
        host_rx_rd <= 1'b0;
    endtask
    // change the vector only while the command bit is clear
    task automatic send_cmd(input logic [7:0] v);
        ready_wait(2);
        host_cmd_wr <= 1'b1;
        host_cmd_vec <= v;
        @(posedge clk);
        host_cmd_wr <= 1'b0;
        host_cmd_vec <= ~v;
    endtask
endmodule // host_model

// [testbench/host_port_pin_function_select_test.sv]
// self-checking bench for the host port pin-function block
`timescale 1ns/100ps
module host_port_pin_function_select_test;
    // clock, reset and register port
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    host_port_pkg::reg_req_t req = '0;
    logic [23:0] rdata;
    logic irq;
    // host side and pads
    logic host_tx_wr, host_rx_rd, host_cmd_wr;
    logic [23:0] host_tx_data, host_rx_data;
    logic [7:0] host_cmd_vec, command_vector;
    logic [21:0] pad_in;
    host_port_pkg::pad_drive_t pad;
    // decoded fields and flags
    logic [10:0] generic_address;
    logic [15:0] muxed_addr_data_in;
    logic [3:0] command_byte_enable_lines;
    logic target_ready_in, initiator_ready_in, host_command_bit;
    logic receive_full_flag, transmit_empty_flag;
    int miscompares = 0;
    int checks_done = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    host_port_pin_function_select dut (.clk, .rst_b, .req, .rdata, .irq, .host_tx_wr,
        .host_tx_data, .host_rx_rd, .host_cmd_wr, .host_cmd_vec, .pad_in, .pad,
        .generic_address, .muxed_addr_data_in, .command_byte_enable_lines, .target_ready_in,
        .initiator_ready_in, .command_vector, .host_command_bit, .host_rx_data,
        .receive_full_flag, .transmit_empty_flag);
    host_model host (.clk, .transmit_empty_flag, .receive_full_flag, .host_command_bit,
        .host_rx_data, .pad, .host_tx_wr, .host_tx_data, .host_rx_rd, .host_cmd_wr,
        .host_cmd_vec, .pad_in);
    // word compare
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // flag compare
    task automatic chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // one-cycle write strobe
    task automatic reg_wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    // read, then take the data in the one cycle it stands
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [23:0] exp);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask
    // let flopped outputs land before sampling
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // reset values and an unmapped place
    task automatic t_reset();
        rd_chk("control", host_port_pkg::OFS_CTRL, '0);
        rd_chk("direction", host_port_pkg::OFS_DIR, '0);
        rd_chk("status", host_port_pkg::OFS_STATUS, '0);
        rd_chk("mask", host_port_pkg::OFS_MASK, '0);
        rd_chk("unmapped", 4'hF, '0);
    endtask
    // every mode code against one pad pattern
    task automatic t_modes();
        logic [21:0] p, dir, gout;
        p = 22'h15_A5C3;
        dir = 22'h0F_00FF;
        gout = 22'h2A_5A5A;
        host.host_level <= p;
        reg_wr(host_port_pkg::OFS_DIR, 24'(dir));
        reg_wr(host_port_pkg::OFS_GPIO_OUT, 24'(gout));
        for (int m = 0; m < 4; m++)
        begin
            reg_wr(host_port_pkg::OFS_CTRL, 24'(m));
            settle(3);
            rd_chk("control", host_port_pkg::OFS_CTRL, 24'(m));
            case (m)
                0:
                begin
                    chk("gpio oe", 24'(dir), 24'(pad.oe));
                    chk("gpio out", 24'(dir & gout), 24'(dir & pad.out));
                    rd_chk("gpio in", host_port_pkg::OFS_GPIO_IN,
                        24'((dir & gout) | (~dir & p)));
                end
                1:
                begin
                    chk("ad lines", 24'(p[15:0]), 24'(muxed_addr_data_in));
                    chk("cbe lines", 24'(p[19:16]), 24'(command_byte_enable_lines));
                    chk1("trdy", p[20], target_ready_in);
                    chk1("irdy", p[21], initiator_ready_in);
                    chk("pci idle oe", '0, 24'(pad.oe));
                    chk("pci address", '0, 24'(generic_address));
                end
                2:
                begin
                    chk("address", 24'({p[7:0], p[18:16]}), 24'(generic_address));
                    chk("generic ad", '0, 24'(muxed_addr_data_in));
                    chk("addr pins oe", '0, 24'(pad.oe & 22'h07_00FF));
                    chk("en dir oe", 24'h00_0003, 24'(pad.oe[21:20]));
                    chk("en dir idle", '0, 24'(pad.out[21:20]));
                end
                default: chk("off oe", '0, 24'(pad.oe));
            endcase
        end
        // generic mode with the direction pin's polarity flipped
        reg_wr(host_port_pkg::OFS_CTRL, 24'(host_port_pkg::MODE_GENERIC)
            | (24'h00_0001 << host_port_pkg::DIR_POL_BIT));
        settle(3);
        chk1("dir pin inverted", 1'b1, pad.out[21]);
        chk1("enable pin idle", 1'b0, pad.out[20]);
    endtask
    // back-to-back transmit writes: the second waits behind a full core register
    task automatic t_tx();
        reg_wr(host_port_pkg::OFS_CTRL, 24'(host_port_pkg::MODE_PCI));
        host.send_tx(24'hA1_B2C3);
        settle(4);
        chk1("tx empty after move", 1'b1, transmit_empty_flag);
        host.send_tx(24'h5D_6E7F);
        settle(4);
        chk1("tx held", 1'b0, transmit_empty_flag);
        rd_chk("core rx first", host_port_pkg::OFS_CORE_RX, 24'hA1_B2C3);
        settle(4);
        chk1("tx empty again", 1'b1, transmit_empty_flag);
        rd_chk("core rx second", host_port_pkg::OFS_CORE_RX, 24'h5D_6E7F);
        rd_chk("status tx", host_port_pkg::OFS_STATUS, 24'h00_0002);
        chk1("irq masked", 1'b0, irq);
        reg_wr(host_port_pkg::OFS_MASK, 24'h00_0002);
        settle(2);
        chk1("irq raised", 1'b1, irq);
        reg_wr(host_port_pkg::OFS_STATUS, 24'h00_0002);
        settle(2);
        chk1("irq cleared", 1'b0, irq);
    endtask
    // core word to the host, read by a slow host
    task automatic t_rx();
        logic [23:0] d;
        reg_wr(host_port_pkg::OFS_CORE_TX, 24'hC0_FFEE);
        settle(2);
        chk1("rx full", 1'b1, receive_full_flag);
        host.gap = 3;
        host.read_rx(d);
        chk("host rx data", 24'hC0_FFEE, d);
        settle(2);
        chk1("rx full cleared", 1'b0, receive_full_flag);
        rd_chk("status rx", host_port_pkg::OFS_STATUS, 24'h00_0001);
        reg_wr(host_port_pkg::OFS_STATUS, 24'h00_0001);
    endtask
    // command vector taken, cleared by the core, taken again
    task automatic t_cmd();
        host.send_cmd(8'h5A);
        settle(2);
        chk("vector", 24'h00_005A, 24'(command_vector));
        chk1("command bit", 1'b1, host_command_bit);
        rd_chk("status cmd", host_port_pkg::OFS_STATUS, 24'h00_0004);
        reg_wr(host_port_pkg::OFS_CMD, 24'h00_0001);
        settle(2);
        chk1("command cleared", 1'b0, host_command_bit);
        host.send_cmd(8'h3C);
        settle(2);
        chk("vector again", 24'h00_003C, 24'(command_vector));
    endtask
    // reset in mid-run while gpio outputs are driven
    task automatic t_rst2();
        reg_wr(host_port_pkg::OFS_CTRL, '0);
        settle(3);
        chk("gpio driving", 24'h0F_00FF, 24'(pad.oe));
        @(posedge clk);
        rst_b <= 1'b0;
        settle(2);
        chk("oe in reset", '0, 24'(pad.oe));
        chk1("tx empty in reset", 1'b1, transmit_empty_flag);
        @(posedge clk);
        rst_b <= 1'b1;
        rd_chk("control after reset", host_port_pkg::OFS_CTRL, '0);
    endtask
    // verdict and end of run
    task automatic results();
        if (miscompares == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        chk("oe held in reset", '0, 24'(pad.oe));
        rst_b <= 1'b1;
        t_reset();
        t_modes();
        t_tx();
        t_rx();
        t_cmd();
        t_rst2();
        results();
    end
    // watchdog: the whole run needs well under 4000 cycles
    initial
    begin
        #20000;
        miscompares++;
        results();
    end
endmodule // host_port_pin_function_select_test
